// [asp_defines.svh]
// Constants shared by both ends of the converter serial port.
// Assumes a 50 MHz system clock on both ends.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
// ****************************************
// Clock and timing
// ****************************************
`define ASP_CLK_HZ      64'd50000000
`define ASP_FMCLK_HZ    64'd76800
`define ASP_CYC_MIN(n)  ((((n)*`ASP_CLK_HZ)+`ASP_FMCLK_HZ-64'd1)/`ASP_FMCLK_HZ)
`define ASP_CYC_MAX(n)  (((n)*`ASP_CLK_HZ)/`ASP_FMCLK_HZ)
`define ASP_BSY_MCLK    64'd4
`define ASP_QUIET_MCLK  64'd4
`define ASP_RDYH_MCLK   64'd4
`define ASP_SYNC_MCLK   64'd4
`define ASP_SYNCH_MCLK  64'd5
`define ASP_WRGAP_MCLK  64'd3
`define ASP_RST_MCLK    64'd11550
`define ASP_INTRD_X2    64'd3
`define ASP_CLK_NS      64'd20
`define ASP_REL0_NS     64'd10
`define ASP_REL1_NS     64'd100
`define ASP_NS_CYC(t)   (((t)+`ASP_CLK_NS-64'd1)/`ASP_CLK_NS)
`define ASP_HALF_CYC    4'h8
// ****************************************
// Device registers and fields
// ****************************************
`define ASP_RA_STAT     7'h00
`define ASP_RA_CONV     7'h01
`define ASP_RA_FIFO     7'h02
`define ASP_RA_IOC      7'h03
`define ASP_RA_DATA     7'h04
`define ASP_RA_ERR      7'h05
`define ASP_CMD_RD      7
`define ASP_CV_4W       0
`define ASP_CV_DLY      1
`define ASP_CV_CONT     2
`define ASP_CV_STBY     3
`define ASP_CV_SRST     4
`define ASP_CV_CRC      5
`define ASP_EXIT_CONT   8'h5A
`define ASP_FIFO_DEPTH  3'h4
// ****************************************
// Host controller registers
// ****************************************
`define ASP_HR_TX       8'h00
`define ASP_HR_CTRL     8'h04
`define ASP_HR_STAT     8'h08
`define ASP_HR_IST      8'h0C
`define ASP_HR_ICLR     8'h10
`define ASP_HR_IEN      8'h14
`endif

// [asp_pkg.sv]
// Types and the pin filter of the converter serial port.
// Assumes asp_defines.svh is on the include path.
package asp_pkg;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_LEAD  = 2'b01,
    H_SHIFT = 2'b10,
    H_TAIL  = 2'b11
  } asp_hst_t;

  typedef struct packed {
    logic [3:0]      s1, s2, s3, pv;
    logic            act;
    logic [3:0]      bits;
    logic [7:0]      shi, cmd, sho;
    logic            dout, oe, irq;
    logic [5:0]      ctl;
    logic [1:0]      isel;
    logic [2:0]      wm;
    logic [3:0][7:0] fifo;
    logic [1:0]      wp, rp;
    logic [2:0]      cnt;
    logic [7:0]      last, pdat;
    logic            rdy_n, pend;
    logic [11:0]     rdyh, bsy, qt, syn;
    logic [2:0]      rel;
  } asp_dev_st_t;

  typedef struct packed {
    logic [1:0]  s1, s2, s3, pv;
    asp_hst_t    st;
    logic [3:0]  div;
    logic [4:0]  nb;
    logic [15:0] sh, rx;
    logic [16:0] ptx;
    logic        pend, len8, fw;
    logic [23:0] gap;
    logic        sclk, cs_n, mosi, sync_n;
    logic [11:0] syn;
    logic [2:0]  ist, ien;
    logic        irq;
    logic [31:0] rdata;
  } asp_host_st_t;

  // A pin takes a new level once the second and third stages agree.
  function automatic logic [3:0] asp_filt(input logic [3:0] a, input logic [3:0] b,
                                          input logic [3:0] p);
    asp_filt = (a & b) | (p & (a ^ b));
  endfunction : asp_filt
endpackage : asp_pkg

// [asp_link_if.sv]
// Serial link between the converter port and its host controller.
// The data-out wire floats high through a pull-up when undriven.
`timescale 1ns/1ps
interface asp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic sync_n;
  logic miso;
  logic miso_oe;
  logic miso_w;
  logic irq;
  assign miso_w = miso_oe ? miso : 1'b1;
  modport dev  (input sclk, cs_n, mosi, sync_n, output miso, miso_oe, irq);
  modport host (output sclk, cs_n, mosi, sync_n, input miso_w, irq);
endinterface : asp_link_if

// [asp_dev.sv]
// Converter end of the serial port: mode 3 slave, control registers,
// a small result FIFO with ready, watermark and clear handling.
// Assumes the link pins are asynchronous to clk_i.
// Behaviour
// - Mode 3: drive on fall, sample on rise.
// - Four-wire select resets 0; 1 enables framing.
// - Release delay select only in 3-wire.
// - 4-wire: output tristated while select high.
// - 3-wire: select still gates the output.
// - Continuous read shifts results without command.
// - Host waits after soft reset transaction.
// - Host holds sync low four periods; asp_host holds it low five.
// - Standby exit resumes within 36 periods.
// - FIFO busy drives ready high four periods.
// - Host waits 1.5 periods after interrupt.
// - Host may read right after ready falls.
// - No ready rise within four after read.
// - FIFO clear completes within eight periods.
// - Routing 0 puts ready and FIFO interrupt.
// - Host spaces control writes three to four.
// - Ready pulses high four before new low.
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_dev (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Conversion results
  input  wire logic [7:0] conv_data_i,
  input  wire logic       conv_valid_i,
  // Mode status
  output logic            standby_o,
  output logic            continuous_read_en_o,
  // Serial link
  asp_link_if.dev         lnk
);
  import asp_pkg::*;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [11:0] BSY_C  = 12'(`ASP_CYC_MIN(`ASP_BSY_MCLK));
  localparam logic [11:0] QT_C   = 12'(`ASP_CYC_MIN(`ASP_QUIET_MCLK));
  localparam logic [11:0] RDYH_C = 12'(`ASP_CYC_MIN(`ASP_RDYH_MCLK));
  localparam logic [11:0] SYNC_C = 12'(`ASP_CYC_MIN(`ASP_SYNC_MCLK));
  localparam logic [2:0]  REL0_C = 3'(`ASP_NS_CYC(`ASP_REL0_NS));
  localparam logic [2:0]  REL1_C = 3'(`ASP_NS_CYC(`ASP_REL1_NS));

  localparam asp_dev_st_t RST_V = '{s1: 4'hF, s2: 4'hF, s3: 4'hF, pv: 4'hF,
                                    rdy_n: 1'b1, irq: 1'b1, default: '0};

  asp_dev_st_t q;
  asp_dev_st_t d;
  logic        fall;
  logic        rise;
  logic        csr;
  logic        fw;
  logic        cont;
  logic        din;
  logic        fr_end;
  logic        push;
  logic        pop;
  logic        clr;
  logic        wmf;
  logic [7:0]  byt;
  logic [7:0]  v;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d      = q;
    fr_end = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    clr    = 1'b0;
    v      = 8'h00;
    d.s1   = {lnk.sync_n, lnk.mosi, lnk.cs_n, lnk.sclk};
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.pv   = asp_filt(q.s2, q.s3, q.pv);
    fall   = q.pv[0] & ~d.pv[0];
    rise   = ~q.pv[0] & d.pv[0];
    csr    = ~q.pv[1] & d.pv[1];
    fw     = q.ctl[`ASP_CV_4W];
    cont   = q.ctl[`ASP_CV_CONT];
    din    = d.pv[2];
    byt    = {q.shi[6:0], din};
    wmf    = (q.wm != 3'h0) && (q.cnt >= q.wm);

    if (q.bsy != 12'h000) begin
      d.bsy = q.bsy - 12'h001;
    end
    if (q.qt != 12'h000) begin
      d.qt = q.qt - 12'h001;
    end
    if (q.rel != 3'h0) begin
      d.rel = q.rel - 3'h1;
    end
    if (q.rdyh != 12'h000) begin
      d.rdyh = q.rdyh - 12'h001;
      if (q.rdyh == 12'h001) begin
        d.rdy_n = 1'b0;
      end
    end

    // A held result enters the FIFO only outside a read and its quiet time.
    if (q.pend && !q.act && q.qt == 12'h000 && q.bsy == 12'h000) begin
      d.pend = 1'b0;
      d.bsy  = BSY_C;
      push   = 1'b1;
    end

    // Results are taken at once after standby is left.
    if (conv_valid_i && !q.ctl[`ASP_CV_STBY]) begin
      d.last = conv_data_i;
      d.pdat = conv_data_i;
      d.pend = 1'b1;
      if (!q.rdy_n) begin
        d.rdy_n = 1'b1;
        d.rdyh  = RDYH_C;
      end else begin
        d.rdy_n = 1'b0;
        d.rdyh  = 12'h000;
      end
    end

    // ****************************************
    // Serial shifter
    // ****************************************
    if (fw && csr) begin
      d.act  = 1'b0;
      d.bits = 4'h0;
    end else if (fall && !(fw && d.pv[1])) begin
      v      = q.act ? q.sho : (cont ? q.last : 8'h00);
      d.dout = v[7];
      d.sho  = {v[6:0], 1'b0};
      d.act  = 1'b1;
    end else if (rise && q.act) begin
      d.shi  = byt;
      d.bits = q.bits + 4'h1;
      if (q.bits == 4'h7 && cont) begin
        fr_end  = 1'b1;
        d.rdy_n = 1'b1;
        if (byt == `ASP_EXIT_CONT) begin
          d.ctl[`ASP_CV_CONT] = 1'b0;
        end
      end else if (q.bits == 4'h7) begin
        d.cmd = byt;
        case (byt[6:0])
          `ASP_RA_STAT: d.sho = {q.cnt, wmf, q.rdy_n, q.pend, 2'b00};
          `ASP_RA_CONV: d.sho = {2'b00, q.ctl};
          `ASP_RA_FIFO: d.sho = {5'h00, q.wm};
          `ASP_RA_IOC:  d.sho = {6'h00, q.isel};
          `ASP_RA_DATA: d.sho = (q.cnt != 3'h0) ? q.fifo[q.rp] : q.last;
          default:      d.sho = 8'h00;
        endcase
      end else if (q.bits == 4'hF) begin
        fr_end = 1'b1;
        if (q.cmd[`ASP_CMD_RD]) begin
          if (q.cmd[6:0] == `ASP_RA_DATA) begin
            d.rdy_n = 1'b1;
            pop     = (q.cnt != 3'h0);
          end
        end else begin
          case (q.cmd[6:0])
            `ASP_RA_CONV: begin
              if (byt[`ASP_CV_SRST]) begin
                d.ctl  = 6'h00;
                d.isel = 2'b00;
                d.wm   = 3'h0;
                clr    = 1'b1;
              end else begin
                d.ctl = byt[5:0];
              end
            end
            `ASP_RA_FIFO: begin
              d.wm = byt[2:0];
              clr  = 1'b1;
            end
            `ASP_RA_IOC: d.isel = byt[1:0];
            default: d.isel = q.isel;
          endcase
        end
      end
    end

    if (fr_end) begin
      d.act  = 1'b0;
      d.bits = 4'h0;
      d.qt   = QT_C;
      d.rel  = q.ctl[`ASP_CV_DLY] ? REL1_C : REL0_C;
    end

    // A result that lands as a read ends still marks data ready.
    if (fr_end && conv_valid_i && !q.ctl[`ASP_CV_STBY] && q.rdy_n) begin
      d.rdy_n = 1'b0;
    end

    // ****************************************
    // Sync pulse and FIFO
    // ****************************************
    if (!d.pv[3]) begin
      if (q.syn != SYNC_C) begin
        d.syn = q.syn + 12'h001;
      end
      if (q.syn == SYNC_C - 12'h001) begin
        clr = 1'b1;
      end
    end else begin
      d.syn = 12'h000;
    end

    if (clr) begin
      d.wp   = 2'b00;
      d.rp   = 2'b00;
      d.cnt  = 3'h0;
      d.pend = 1'b0;
    end else begin
      if (push && q.cnt != `ASP_FIFO_DEPTH) begin
        d.fifo[q.wp] = q.pdat;
        d.wp         = q.wp + 2'b01;
      end
      if (pop) begin
        d.rp = q.rp + 2'b01;
      end
      d.cnt = q.cnt + 3'((push && q.cnt != `ASP_FIFO_DEPTH) ? 1 : 0)
                    - 3'(pop ? 1 : 0);
    end

    // ****************************************
    // Pins
    // ****************************************
    // The busy level waits out the quiet time, so a read never ends in a rising output.
    if (!d.act && d.bsy != 12'h000 && d.qt == 12'h000) begin
      d.dout = 1'b1;
    end
    if (fw) begin
      d.oe = ~d.pv[1];
    end else begin
      d.oe = ~d.pv[1] & (d.act | d.rel != 3'h0 | d.bsy != 12'h000);
    end
    case (q.isel)
      2'b00:   d.irq = d.rdy_n | wmf;
      2'b01:   d.irq = d.rdy_n;
      2'b10:   d.irq = wmf;
      default: d.irq = 1'b1;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_V;
    end else begin
      q <= d;
    end
  end

  assign lnk.miso    = q.dout;
  assign lnk.miso_oe = q.oe;
  assign lnk.irq     = q.irq;
  assign standby_o   = q.ctl[`ASP_CV_STBY];
  assign continuous_read_en_o = q.ctl[`ASP_CV_CONT];
endmodule : asp_dev

// [asp_host.sv]
// Host end of the serial port: mode 3 master with its own registers.
// Assumes the interrupt and data-out pins are asynchronous to clk_i.
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_host #(
  parameter int RST_WAIT = int'(`ASP_CYC_MIN(`ASP_RST_MCLK)),
  parameter int WR_GAP   = int'(`ASP_CYC_MIN(`ASP_WRGAP_MCLK))
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o,
  // Serial link
  asp_link_if.host         lnk
);
  import asp_pkg::*;

  localparam logic [23:0] INTRD_C = 24'((`ASP_INTRD_X2 * `ASP_CLK_HZ + 2 * `ASP_FMCLK_HZ - 1)
                                        / (2 * `ASP_FMCLK_HZ));
  localparam logic [11:0] SYNC_C  = 12'(`ASP_CYC_MIN(`ASP_SYNCH_MCLK));
  localparam asp_host_st_t RST_V  = '{s1: 2'b11, s2: 2'b11, s3: 2'b11, pv: 2'b11,
                                      st: H_IDLE, sclk: 1'b1, cs_n: 1'b1,
                                      mosi: 1'b1, sync_n: 1'b1, default: '0};

  asp_host_st_t q;
  asp_host_st_t d;
  logic [3:0]   f;

  always_comb begin
    d    = q;
    d.s1 = {lnk.irq, lnk.miso_w};
    d.s2 = q.s1;
    d.s3 = q.s2;
    f    = asp_filt({2'b11, q.s2}, {2'b11, q.s3}, {2'b11, q.pv});
    d.pv = f[1:0];
    if (q.gap != 24'h0) begin
      d.gap = q.gap - 24'h1;
    end
    if (q.syn != 12'h000) begin
      d.syn = q.syn - 12'h001;
      if (q.syn == 12'h001) begin
        d.sync_n = 1'b1;
      end
    end

    // ****************************************
    // Register port
    // ****************************************
    d.rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        `ASP_HR_CTRL: d.rdata = {31'h0, q.fw};
        `ASP_HR_STAT: d.rdata = {q.rx, 13'h0, q.gap != 24'h0, q.pend, q.st != H_IDLE};
        `ASP_HR_IST:  d.rdata = {29'h0, q.ist};
        `ASP_HR_IEN:  d.rdata = {29'h0, q.ien};
        default:      d.rdata = 32'h0;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        `ASP_HR_TX: begin
          if (!q.pend) begin
            d.ptx  = wdata_i[16:0];
            d.pend = 1'b1;
          end
        end
        `ASP_HR_CTRL: begin
          if (q.st == H_IDLE) begin
            d.fw = wdata_i[0];
          end
          if (wdata_i[1] && q.syn == 12'h000) begin
            d.syn    = SYNC_C;
            d.sync_n = 1'b0;
          end
        end
        `ASP_HR_ICLR: d.ist = q.ist & ~wdata_i[2:0];
        `ASP_HR_IEN:  d.ien = wdata_i[2:0];
        default: d.ien = q.ien;
      endcase
    end

    // Events set after the clear so that a set in the same cycle wins.
    if (!q.pv[1] && d.pv[1]) begin
      d.ist[1] = 1'b1;
      if (d.gap < INTRD_C) begin
        d.gap = INTRD_C;
      end
    end
    if (q.pv[0] && !d.pv[0] && q.st == H_IDLE) begin
      d.ist[2] = 1'b1;
    end

    // ****************************************
    // Frame sequencer
    // ****************************************
    case (q.st)
      H_IDLE: begin
        d.cs_n = q.fw;
        d.sclk = 1'b1;
        if (q.pend && q.gap == 24'h0 && q.sync_n) begin
          d.sh   = q.ptx[15:0];
          d.len8 = q.ptx[16];
          d.nb   = 5'h00;
          d.pend = 1'b0;
          d.div  = 4'h0;
          d.cs_n = 1'b0;
          d.st   = q.fw ? H_LEAD : H_SHIFT;
        end
      end
      H_LEAD: begin
        d.div = q.div + 4'h1;
        if (q.div == `ASP_HALF_CYC - 4'h1) begin
          d.div = 4'h0;
          d.st  = H_SHIFT;
        end
      end
      H_SHIFT: begin
        d.div = q.div + 4'h1;
        if (q.div == 4'h0) begin
          d.sclk = 1'b0;
          d.mosi = q.sh[15];
          d.sh   = {q.sh[14:0], 1'b0};
        end
        if (q.div == `ASP_HALF_CYC) begin
          d.sclk = 1'b1;
        end
        if (q.div == 4'hF) begin
          d.rx = {q.rx[14:0], q.pv[0]};
          d.nb = q.nb + 5'h01;
          if (q.nb == (q.len8 ? 5'h07 : 5'h0F)) begin
            d.st = H_TAIL;
          end
        end
      end
      H_TAIL: begin
        d.div = q.div + 4'h1;
        if (q.div == `ASP_HALF_CYC - 4'h1) begin
          d.cs_n   = q.fw;
          d.st     = H_IDLE;
          d.ist[0] = 1'b1;
          if (!q.len8 && !q.ptx[15] && q.ptx[14:8] == `ASP_RA_CONV && q.ptx[`ASP_CV_SRST]) begin
            d.gap = 24'(RST_WAIT);
          end else if (!q.len8 && !q.ptx[15] &&
                       (q.ptx[14:8] == `ASP_RA_CONV || q.ptx[14:8] == `ASP_RA_ERR)) begin
            d.gap = 24'(WR_GAP);
          end
        end
      end
      default: d.st = H_IDLE;
    endcase
    d.irq = |(d.ist & d.ien);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_V;
    end else begin
      q <= d;
    end
  end

  assign lnk.sclk   = q.sclk;
  assign lnk.cs_n   = q.cs_n;
  assign lnk.mosi   = q.mosi;
  assign lnk.sync_n = q.sync_n;
  assign rdata_o    = q.rdata;
  assign irq_o      = q.irq;
endmodule : asp_host

// [asp_link_monitor.sv]
// Checker for the serial link between the converter port and its host.
// Assumes it sees the link wires and the shared clock and reset directly.
`timescale 1ns/1ps
module asp_link_monitor (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link wires
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic sync_n,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic irq
);
  // ****************************************
  // Sync pulse width counter
  // ****************************************
  localparam int SYNC_MIN = 2605;
  logic [11:0] sync_cnt_q;
  logic [11:0] sync_cnt_d;

  always_comb begin
    sync_cnt_d = sync_cnt_q;
    if (sync_n) begin
      sync_cnt_d = 12'h000;
    end else if (sync_cnt_q != 12'hFFF) begin
      sync_cnt_d = sync_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_cnt_q <= 12'h000;
    end else begin
      sync_cnt_q <= sync_cnt_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_sclk_idle_high: assert property ($fell(cs_n) |-> sclk)
    else $error("Serial clock low when select fell");
  a_cs_rise_high: assert property ($rose(cs_n) |-> sclk && $past(sclk, 4))
    else $error("Select rose while serial clock was low");
  a_sclk_low_phase: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("Serial clock low phase is not eight cycles");
  a_sclk_high_phase: assert property ($rose(sclk) |-> sclk [*8])
    else $error("Serial clock high phase shorter than eight cycles");
  a_mosi_at_rise: assert property ($rose(sclk) |-> $stable(mosi) ##1 $stable(mosi))
    else $error("Data in moved around the sampling edge");
  a_miso_while_high: assert property ($rose(sclk) && miso_oe |-> ##1 $stable(miso) [*5])
    else $error("Data out moved while serial clock was high");
  a_oe_off_deselect: assert property (cs_n [*8] |-> !miso_oe)
    else $error("Data out driven while select is high");
  a_sync_width: assert property ($rose(sync_n) |-> sync_cnt_q >= SYNC_MIN)
    else $error("Sync pulse shorter than four periods");

  c_frame_start: cover property ($fell(cs_n));
  c_sync_pulse: cover property ($rose(sync_n));
  c_irq_rise: cover property ($rose(irq));
  c_out_release: cover property ($fell(miso_oe));
endmodule : asp_link_monitor

// [tb_top.sv]
// Self-checking bench joining host controller and converter port.
// Assumes asp_defines.svh on the include path; reset gap is shortened.
`timescale 1ns/1ps
`include "asp_defines.svh"
module tb_top;
  localparam int RST_WAIT = 2000;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic [7:0]  addr_i       = 8'h00;
  logic [31:0] wdata_i      = 32'h0000_0000;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic [7:0]  conv_data_i  = 8'h00;
  logic        conv_valid_i = 1'b0;
  logic        standby_o;
  logic        continuous_read_en_o;
  logic [31:0] rnd          = 32'h52A6ADD9;
  int          error_cnt    = 0;
  int          comparisons  = 0;
  int          cycles       = 0;

  asp_link_if lnk_if ();
  asp_dev asp_dev_i (.clk_i(clk_i), .rst_i(rst_i), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
    .standby_o(standby_o), .continuous_read_en_o(continuous_read_en_o), .lnk(lnk_if));
  asp_host #(.RST_WAIT(RST_WAIT)) asp_host_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .lnk(lnk_if));
  asp_link_monitor asp_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(lnk_if.sclk), .cs_n(lnk_if.cs_n),
    .mosi(lnk_if.mosi), .sync_n(lnk_if.sync_n), .miso(lnk_if.miso), .miso_oe(lnk_if.miso_oe), .irq(lnk_if.irq));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // The result store holds four entries at most.
  function automatic logic [2:0] exp_cnt(input int n);
    exp_cnt = (n > 4) ? 3'h4 : 3'(n);
  endfunction : exp_cnt

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : bus_rd

  // Polls until no frame is busy, pending or waiting out its gap.
  task automatic wait_idle();
    logic [31:0] s;
    int          n;
    s = 32'h0000_0007;
    n = 0;
    while (s[2:0] !== 3'b000 && n < 30000) begin
      bus_rd(`ASP_HR_STAT, s);
      n++;
    end
    if (n >= 30000) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wait_idle

  task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
    bus_wr(`ASP_HR_TX, {16'h0000, 1'b0, a, d});
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic [6:0] a, output logic [7:0] d);
    logic [31:0] s;
    bus_wr(`ASP_HR_TX, {16'h0000, 1'b1, a, 8'h00});
    wait_idle();
    bus_rd(`ASP_HR_STAT, s);
    d = s[23:16];
  endtask : dev_rd

  // Hands one result to the converter and lets its busy time run out.
  task automatic push(input logic [7:0] b);
    @(posedge clk_i);
    conv_data_i  <= b;
    conv_valid_i <= 1'b1;
    @(posedge clk_i);
    conv_valid_i <= 1'b0;
    repeat (3000) @(posedge clk_i);
  endtask : push

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] s;
    logic [7:0]  b;
    logic [7:0]  q [$];
    int          t0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_rd(`ASP_HR_STAT, s);
    chk("host status", s, 32'h0);
    bus_rd(8'h40, s);
    chk("unmapped read", s, 32'h0);
    bus_wr(`ASP_HR_IEN, 32'h1);
    dev_rd(`ASP_RA_CONV, b);
    chk("control reset", b, 8'h00);
    chk("irq frame done", irq_o, 32'h1);
    bus_wr(`ASP_HR_ICLR, 32'h1);
    bus_rd(`ASP_HR_IST, s);
    chk("irq cleared", irq_o, 32'h0);
    bus_wr(`ASP_HR_IEN, 32'h0);
    dev_rd(`ASP_RA_CONV, b);
    bus_rd(`ASP_HR_IST, s);
    chk("irq masked", irq_o, 32'h0);
    chk("done sticky", s[0], 32'h1);
    for (int i = 0; i < 3; i++) begin
      rnd = (i == 0) ? 32'hFFFF_FFFF : lfsr(rnd);
      dev_wr(`ASP_RA_FIFO, {5'h00, rnd[2:0]});
      dev_wr(`ASP_RA_IOC, {6'h00, rnd[5:4]});
      dev_rd(`ASP_RA_FIFO, b);
      chk("watermark", b, {5'h00, rnd[2:0]});
      dev_rd(`ASP_RA_IOC, b);
      chk("routing", b, {6'h00, rnd[5:4]});
    end
    dev_wr(`ASP_RA_CONV, 8'h08);
    chk("standby on", standby_o, 32'h1);
    dev_wr(`ASP_RA_CONV, 8'h00);
    chk("standby off", standby_o, 32'h0);
    dev_wr(`ASP_RA_IOC, 8'h00);
    dev_wr(`ASP_RA_FIFO, 8'h07);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      q.push_back(rnd[15:8]);
      push(rnd[15:8]);
    end
    dev_rd(`ASP_RA_STAT, b);
    chk("store count", b[7:5], exp_cnt(2));
    dev_rd(`ASP_RA_DATA, b);
    chk("first result", b, q.pop_front());
    dev_rd(`ASP_RA_DATA, b);
    chk("second result", b, q.pop_front());
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      push(rnd[7:0]);
    end
    dev_rd(`ASP_RA_STAT, b);
    chk("full count", b[7:5], exp_cnt(5));
    dev_wr(`ASP_RA_FIFO, 8'h07);
    repeat (5300) @(posedge clk_i);
    dev_rd(`ASP_RA_STAT, b);
    chk("clear by write", b[7:5], exp_cnt(0));
    push(8'hC3);
    bus_wr(`ASP_HR_CTRL, 32'h2);
    repeat (8600) @(posedge clk_i);
    dev_rd(`ASP_RA_STAT, b);
    chk("clear by sync", b[7:5], exp_cnt(0));
    dev_wr(`ASP_RA_CONV, 8'h04);
    chk("continuous on", continuous_read_en_o, 32'h1);
    rnd = lfsr(rnd);
    push(rnd[23:16]);
    bus_wr(`ASP_HR_TX, {15'h0000, 1'b1, `ASP_EXIT_CONT, `ASP_EXIT_CONT});
    wait_idle();
    bus_rd(`ASP_HR_STAT, s);
    chk("continuous result", s[23:16], rnd[23:16]);
    chk("continuous off", continuous_read_en_o, 32'h0);
    dev_wr(`ASP_RA_CONV, 8'h01);
    bus_wr(`ASP_HR_CTRL, 32'h1);
    dev_rd(`ASP_RA_CONV, b);
    chk("four wire", b, 8'h01);
    dev_wr(`ASP_RA_CONV, 8'h03);
    dev_rd(`ASP_RA_CONV, b);
    chk("delay in four wire", b, 8'h03);
    t0 = cycles;
    dev_wr(`ASP_RA_CONV, 8'h10);
    chk("reset gap", (cycles - t0) >= RST_WAIT, 32'h1);
    bus_wr(`ASP_HR_CTRL, 32'h0);
    dev_rd(`ASP_RA_CONV, b);
    chk("soft reset", b, 8'h00);
    give_verdict();
  end
endmodule : tb_top
